// ### hdl/anpx_regs.sv
// partner next page and auto-negotiation expansion registers behind axi4-lite
// assumes the arbitration logic pulses page_done_in once per accepted next page word
// What this block does
// R01: message page flag set means the code field is a formatted message page.
// R02: bit 12 shows whether the partner can comply with the next page message.
// R03: bit 11 reads the inverse of our previously transmitted toggle bit.
// R04: bits 10:0 hold the received code field, read only, reset to zero.
// R05: expansion bits 15:5 ignore writes and read as zero.
// R06: expansion bit 4 shows a parallel detection fault, zero otherwise.
// R07: expansion bit 3 shows partner next page support.
// R08: expansion bit 2 reads as constant one, writes have no effect.
// R09: expansion bit 1 is set on page receipt, cleared by reading it.
// R10: expansion bit 0 shows partner auto-negotiation support.
// R11: next page fields and page received flag update together on acceptance.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
module anpx_regs
  import anpx_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        page_done_in,
  input  wire logic [15:0] page_word_in,
  input  wire logic        tx_toggle_in,
  input  wire logic        parallel_detect_fault_in,
  input  wire logic        partner_next_page_capable_in,
  input  wire logic        partner_autoneg_capable_in,
  output logic             message_page_flag_out,
  output logic [10:0]      page_code_out,
  output logic             irq_out
);

  // write channel state
  logic                  aw_have_q, aw_have_d;
  logic                  w_have_q, w_have_d;
  logic [7:0]            awaddr_q, awaddr_d;
  logic [31:0]           wdata_q, wdata_d;
  logic [3:0]            wstrb_q, wstrb_d;
  logic                  awready_q, awready_d;
  logic                  wready_q, wready_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  wr_en;
  // read channel state
  anpx_rd_t              rd_state_q, rd_state_d;
  logic                  arready_q, arready_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;
  logic                  rd_exp;
  // register contents
  logic [15:0]           pnp_q, pnp_d;
  logic                  prx_q, prx_d;
  logic                  pdf_q, lpnp_q, lpan_q;
  logic [ANPX_INT_W-1:0] istat_q, istat_d;
  logic [ANPX_INT_W-1:0] imask_q, imask_d;
  logic [ANPX_INT_W-1:0] events;
  logic                  irq_q, irq_d;

  // read data for an address, unmapped reads return zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ANPX_ADDR_PNP:   v[15:0] = pnp_q;
      ANPX_ADDR_EXP: begin                            // R05
        v[ANPX_EXP_PDF]  = pdf_q;                     // R06
        v[ANPX_EXP_LPNP] = lpnp_q;                    // R07
        v[ANPX_EXP_NPA]  = ANPX_NPA_VAL;              // R08
        v[ANPX_EXP_PRX]  = prx_q;                     // R09
        v[ANPX_EXP_LPAN] = lpan_q;                    // R10
      end
      ANPX_ADDR_ISTAT: v[ANPX_INT_W-1:0] = istat_q;
      ANPX_ADDR_IMASK: v[ANPX_INT_W-1:0] = imask_q;
      default:         v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ANPX_ADDR_PNP) || (a == ANPX_ADDR_EXP) ||
           (a == ANPX_ADDR_ISTAT) || (a == ANPX_ADDR_IMASK);
  endfunction

  // write channel: address and data taken in either order, response after both
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_en     = 1'b0;
    if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid_in && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata_in;
      wstrb_d  = s_axi_wstrb_in;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      wr_en     = 1'b1;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(awaddr_q) ? ANPX_RESP_OKAY : ANPX_RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ANPX_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // read channel: one read under way, data registered at address acceptance
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    rd_exp     = 1'b0;
    case (rd_state_q)
      ANPX_RD_IDLE: begin
        if (s_axi_arvalid_in && arready_q) begin
          rdata_d    = rd_word(s_axi_araddr_in);
          rresp_d    = mapped(s_axi_araddr_in) ? ANPX_RESP_OKAY : ANPX_RESP_SLVERR;
          rd_exp     = (s_axi_araddr_in == ANPX_ADDR_EXP);
          rd_state_d = ANPX_RD_RESP;
        end
      end
      ANPX_RD_RESP: begin
        if (s_axi_rready_in) begin
          rd_state_d = ANPX_RD_IDLE;
        end
      end
      default: rd_state_d = ANPX_RD_IDLE;
    endcase
    arready_d = (rd_state_d == ANPX_RD_IDLE);
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_state_q <= ANPX_RD_IDLE;
      arready_q  <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= ANPX_RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      arready_q  <= arready_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  // page capture, read clear of page received, interrupt status and mask
  always_comb begin
    pnp_d   = pnp_q;
    prx_d   = prx_q;
    istat_d = istat_q;
    imask_d = imask_q;
    events  = '0;
    events[ANPX_INT_PRX] = page_done_in;
    events[ANPX_INT_PDF] = parallel_detect_fault_in && !pdf_q;
    if (rd_exp) begin
      prx_d = 1'b0;                                   // R09
    end
    if (page_done_in) begin
      pnp_d[15:ANPX_PARTNER_COMPLY_ACK_BIT]   = page_word_in[15:ANPX_PARTNER_COMPLY_ACK_BIT]; // R01 R02
      pnp_d[ANPX_TOG_BIT]       = !tx_toggle_in;                  // R03
      pnp_d[ANPX_CODE_MSB:0]    = page_word_in[ANPX_CODE_MSB:0];  // R04
      prx_d                     = 1'b1;               // R11
    end
    if (wr_en && wstrb_q[0] && awaddr_q == ANPX_ADDR_ISTAT) begin
      istat_d = istat_q & ~wdata_q[ANPX_INT_W-1:0];
    end
    if (wr_en && wstrb_q[0] && awaddr_q == ANPX_ADDR_IMASK) begin
      imask_d = wdata_q[ANPX_INT_W-1:0];
    end
    istat_d = istat_d | events;                       // set beats clear
    irq_d   = |(istat_d & imask_d);
  end

  // live partner status is sampled every cycle, expansion is otherwise read only
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pnp_q   <= ANPX_PNP_RST;
      prx_q   <= 1'b0;
      pdf_q   <= 1'b0;
      lpnp_q  <= 1'b0;
      lpan_q  <= 1'b0;
      istat_q <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      pnp_q   <= pnp_d;
      prx_q   <= prx_d;
      pdf_q   <= parallel_detect_fault_in;            // R06
      lpnp_q  <= partner_next_page_capable_in;        // R07
      lpan_q  <= partner_autoneg_capable_in;          // R10
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
    end
  end

  // outputs straight from flops, except rvalid, decoded from the read state
  assign s_axi_awready_out     = awready_q;
  assign s_axi_wready_out      = wready_q;
  assign s_axi_bvalid_out      = bvalid_q;
  assign s_axi_bresp_out       = bresp_q;
  assign s_axi_arready_out     = arready_q;
  assign s_axi_rvalid_out      = (rd_state_q == ANPX_RD_RESP);
  assign s_axi_rdata_out       = rdata_q;
  assign s_axi_rresp_out       = rresp_q;
  assign message_page_flag_out = pnp_q[ANPX_MP_BIT];           // R01
  assign page_code_out         = pnp_q[ANPX_CODE_MSB:0];
  assign irq_out               = irq_q;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic exp_rd_hs;
  assign exp_rd_hs = s_axi_arvalid_in && arready_q && s_axi_araddr_in == ANPX_ADDR_EXP;

  msg_flag_a: assert property (page_done_in |=> message_page_flag_out == $past(page_word_in[ANPX_MP_BIT])) // R01
    else $error("message page flag not captured");
  comply_ack_a: assert property (page_done_in |=> pnp_q[ANPX_PARTNER_COMPLY_ACK_BIT] == $past(page_word_in[ANPX_PARTNER_COMPLY_ACK_BIT])) // R02
    else $error("comply acknowledge not captured");
  toggle_inv_a: assert property (page_done_in |=> pnp_q[ANPX_TOG_BIT] != $past(tx_toggle_in)) // R03
    else $error("toggle not inverse of transmitted");
  code_cap_a: assert property (page_done_in |=> page_code_out == $past(page_word_in[10:0])) // R04
    else $error("code field not captured");
  code_hold_a: assert property (!page_done_in |=> $stable(pnp_q)) // R04
    else $error("next page register changed without page");
  exp_rsvd_a: assert property (exp_rd_hs |=> s_axi_rvalid_out && s_axi_rdata_out[31:5] == 27'h0) // R05
    else $error("expansion reserved bits not zero");
  pdf_read_a: assert property (exp_rd_hs |=> s_axi_rdata_out[4] == $past(parallel_detect_fault_in, 2)) // R06
    else $error("parallel detect fault misreported");
  lpnp_read_a: assert property (exp_rd_hs |=> s_axi_rdata_out[3] == $past(partner_next_page_capable_in, 2)) // R07
    else $error("partner next page ability misreported");
  npa_fixed_a: assert property (exp_rd_hs |=> s_axi_rdata_out[2]) // R08
    else $error("local next page ability not one");
  prx_clear_a: assert property (exp_rd_hs && !page_done_in |=> !prx_q) // R09
    else $error("page received not cleared by read");
  lpan_read_a: assert property (exp_rd_hs |=> s_axi_rdata_out[0] == $past(partner_autoneg_capable_in, 2)) // R10
    else $error("partner autoneg ability misreported");
  page_sync_a: assert property (page_done_in |=> prx_q && istat_q[0] && pnp_q[10:0] == $past(page_word_in[10:0])) // R11
    else $error("page fields and flag not updated together");

  // sticky flags, fault event, read data hold and interrupt level
  prx_hold_a: assert property (prx_q && !rd_exp |=> prx_q) // R09
    else $error("page received dropped without a read");
  pdf_event_a: assert property (parallel_detect_fault_in && !pdf_q |=> istat_q[ANPX_INT_PDF]) // R06
    else $error("fault rise not latched in status");
  rd_stable_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) // R05
    else $error("read data changed before taken");
  irq_level_a: assert property (irq_out == |(istat_q & imask_q)) // R11
    else $error("interrupt level disagrees with status");

endmodule // anpx_regs

// ### hdl/anpx_pkg.sv
// constants for the auto-negotiation partner page and expansion register bank
// assumes a 32-bit axi4-lite slave with byte addresses of four times the register index
package anpx_pkg;
  // register indices and byte addresses
  localparam logic [7:0] ANPX_IDX_PNP   = 8'h05;
  localparam logic [7:0] ANPX_IDX_EXP   = 8'h06;
  localparam logic [7:0] ANPX_IDX_ISTAT = 8'h08;
  localparam logic [7:0] ANPX_IDX_IMASK = 8'h09;
  localparam logic [7:0] ANPX_ADDR_PNP   = {ANPX_IDX_PNP[5:0], 2'b00};
  localparam logic [7:0] ANPX_ADDR_EXP   = {ANPX_IDX_EXP[5:0], 2'b00};
  localparam logic [7:0] ANPX_ADDR_ISTAT = {ANPX_IDX_ISTAT[5:0], 2'b00};
  localparam logic [7:0] ANPX_ADDR_IMASK = {ANPX_IDX_IMASK[5:0], 2'b00};
  // partner next page field positions
  localparam int ANPX_MP_BIT   = 13;
  localparam int ANPX_PARTNER_COMPLY_ACK_BIT = 12;
  localparam int ANPX_TOG_BIT  = 11;
  localparam int ANPX_CODE_MSB = 10;
  localparam logic [15:0] ANPX_PNP_RST = 16'h0000;
  // expansion field positions and values
  localparam int ANPX_EXP_PDF  = 4;
  localparam int ANPX_EXP_LPNP = 3;
  localparam int ANPX_EXP_NPA  = 2;
  localparam int ANPX_EXP_PRX  = 1;
  localparam int ANPX_EXP_LPAN = 0;
  localparam logic ANPX_NPA_VAL = 1'b1;
  // interrupt status layout
  localparam int ANPX_INT_PRX = 0;
  localparam int ANPX_INT_PDF = 1;
  localparam int ANPX_INT_W   = 2;
  // axi response codes
  localparam logic [1:0] ANPX_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ANPX_RESP_SLVERR = 2'b10;
  // read channel states
  typedef enum logic [1:0] {
    ANPX_RD_IDLE = 2'b01,
    ANPX_RD_RESP = 2'b10
  } anpx_rd_t;
endpackage

// ### testbench/anpx_partner.sv
// link partner model: presents received next page words and ability levels
// assumes one clock shared with the register bank, async active-high reset
`timescale 1ns/100ps
module anpx_partner (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        send_in,
  input  wire logic [16:0] page_in,
  input  wire logic [2:0]  lvl_in,
  output logic             page_done_out,
  output logic [15:0]      page_word_out,
  output logic             tx_toggle_out,
  output logic [2:0]       lvl_out
);
  // one pulse per word; word lines scramble when no page is presented
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      page_done_out <= 1'b0;
      {tx_toggle_out, page_word_out} <= 17'h00000;
      lvl_out <= 3'h0;
    end else begin
      page_done_out <= send_in;
      if (send_in) begin
        {tx_toggle_out, page_word_out} <= page_in;
      end else begin
        {tx_toggle_out, page_word_out} <= ~{tx_toggle_out, page_word_out};
      end
      lvl_out <= lvl_in;
    end
  end
endmodule // anpx_partner

// ### testbench/anpx_regs_bench.sv
// self-checking bench for the partner page and expansion register bank
// assumes axi4-lite master tasks and a behavioural model of the registers
`timescale 1ns/100ps
module anpx_regs_bench;
  import anpx_pkg::*;
  logic        clk_sys_in, reset_in, awvalid, wvalid, bready, arvalid, rready, send;
  logic        awready, wready, bvalid, arready, rvalid, pdone, ptog, mpf, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, m_ist, m_msk;
  logic [16:0] page;
  logic [2:0]  lvl, lvl_p;
  logic [15:0] pword, m_pnp;
  logic [10:0] pcode;
  logic        m_prx;
  int          bad_count, total_checks, i;
  anpx_regs DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .page_done_in(pdone), .page_word_in(pword),
    .tx_toggle_in(ptog), .parallel_detect_fault_in(lvl_p[2]),
    .partner_next_page_capable_in(lvl_p[1]), .partner_autoneg_capable_in(lvl_p[0]),
    .message_page_flag_out(mpf), .page_code_out(pcode), .irq_out(irq));
  anpx_partner far_end (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .send_in(send),
    .page_in(page), .lvl_in(lvl), .page_done_out(pdone), .page_word_out(pword),
    .tx_toggle_out(ptog), .lvl_out(lvl_p));
  // clock at 50 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // axi write: both channels offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (n >= 40) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // axi read: data and response taken at the rvalid edge
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk_sys_in);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (n >= 40) begin
      bad_count++;
      give_verdict();
    end
  endtask
  function automatic logic [31:0] expv();
    return {27'h0, lvl[2], lvl[1], ANPX_NPA_VAL, m_prx, lvl[0]};
  endfunction
  // one next page word from the partner, then live outputs compared
  task automatic send_page(input logic [16:0] p);
    @(posedge clk_sys_in);
    send <= 1'b1;
    page <= p;
    @(posedge clk_sys_in);
    send <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    m_pnp = {p[15:12], ~p[16], p[10:0]};
    m_prx = 1'b1;
    m_ist[0] = 1'b1;
    chk(mpf, p[13]);
    chk(pcode, p[10:0]);
    chk(irq, |(m_ist & m_msk));
  endtask
  // main sequence
  initial begin
    {reset_in, awvalid, wvalid, bready, arvalid, rready, send} = 7'h40;
    {awaddr, araddr, wdata, page, lvl} = 0;
    {m_ist, m_msk, m_prx, m_pnp, bad_count, total_checks} = 0;
    void'($urandom(12056));
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    rdr(ANPX_ADDR_PNP);
    chk(rd, 32'h0);
    rdr(ANPX_ADDR_EXP);
    chk(rd, expv());
    wr(ANPX_ADDR_IMASK, 32'h1);
    m_msk = 2'h1;
    for (i = 0; i < 6; i++) begin
      send_page(17'($urandom));
      rdr(ANPX_ADDR_PNP);
      chk(rd, {16'h0, m_pnp});
      rdr(ANPX_ADDR_EXP);
      chk(rd, expv());
      m_prx = 1'b0;
      rdr(ANPX_ADDR_EXP);
      chk(rd, expv());
      wr(ANPX_ADDR_ISTAT, 32'h1);
      m_ist[0] = 1'b0;
      chk(irq, |(m_ist & m_msk));
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      if (i[2] && !lvl[2]) m_ist[1] = 1'b1;
      lvl <= i[2:0];
      repeat (3) @(posedge clk_sys_in);
      rdr(ANPX_ADDR_EXP);
      chk(rd, expv());
    end
    wr(ANPX_ADDR_IMASK, 32'h3);
    m_msk = 2'h3;
    chk(irq, |(m_ist & m_msk));
    rdr(ANPX_ADDR_ISTAT);
    chk(rd, {30'h0, m_ist});
    wr(ANPX_ADDR_ISTAT, 32'h3);
    m_ist = 2'h0;
    chk(irq, 32'h0);
    wr(ANPX_ADDR_IMASK, 32'h0);
    m_msk = 2'h0;
    send_page(17'($urandom));
    wr(ANPX_ADDR_EXP, 32'hffffffff);
    chk(rs, ANPX_RESP_OKAY);
    rdr(ANPX_ADDR_EXP);
    chk(rd, expv());
    wr(ANPX_ADDR_PNP, 32'hffffffff);
    rdr(ANPX_ADDR_PNP);
    chk(rd, {16'h0, m_pnp});
    wr(8'h40, 32'h1);
    chk(rs, ANPX_RESP_SLVERR);
    rdr(8'h40);
    chk(rs, ANPX_RESP_SLVERR);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule // anpx_regs_bench
